// ===== hw/regfile_pkg.sv
package regfile_pkg;

  // Array geometry.
  localparam int unsigned WORDS  = 8;
  localparam int unsigned WIDTH  = 8;
  localparam int unsigned ADDR_W = 3;

  // Published pin timing, kept for reference by the bench.
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned ACCESS_DELAY_NS   = 35;
  localparam int unsigned DISABLE_DELAY_NS  = 25;
  // A longest time rounds down, but never below one cycle.
  localparam int unsigned ACCESS_DELAY_CYC  =
    (ACCESS_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (ACCESS_DELAY_NS / CLK_PERIOD_NS);
  localparam int unsigned DISABLE_DELAY_CYC =
    (DISABLE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (DISABLE_DELAY_NS / CLK_PERIOD_NS);

  // Wishbone register map, byte addresses.
  localparam int unsigned WB_ADR_W = 8;
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] PEEK_BASE_OFS = 8'h20;
  localparam logic [7:0] PEEK_MASK     = 8'he0;

  // Field positions and reset values.
  localparam int unsigned CTRL_ENABLE_BIT    = 0;
  localparam int unsigned STATUS_COLLIDE_BIT = 0;
  localparam logic        CTRL_ENABLE_RST    = 1'b1;
  localparam logic        COLLIDE_RST        = 1'b0;
  localparam logic [31:0] WB_ZERO            = 32'h0000_0000;

  // Bidirectional port direction codes.
  localparam logic DIR_READ  = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // One write request as captured at the address edge.
  typedef struct packed {
    logic              active;
    logic [ADDR_W-1:0] addr;
  } wr_req_t;

endpackage

// ===== hw/wr_port_stage.sv
`timescale 1ns/10ps
module wr_port_stage #(
  parameter int unsigned WORDS  = regfile_pkg::WORDS,
  parameter int unsigned ADDR_W = regfile_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Address edge inputs
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              en_n_i,
  input  wire logic              qual_i,
  // Registered one-hot word select
  output logic [WORDS-1:0]       sel_o
);
  import regfile_pkg::*;

  initial begin
    if (WORDS != (1 << ADDR_W)) begin
      $error("wr_port_stage: WORDS must equal 2**ADDR_W");
    end
  end

  wr_req_t          req;
  logic [WORDS-1:0] sel_nxt;

  assign req.active = qual_i & ~en_n_i;
  assign req.addr   = addr_i;

  assign sel_nxt = req.active ? (WORDS'(1) << req.addr) : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_o <= '0;
    end else begin
      sel_o <= sel_nxt;
    end
  end

endmodule

// ===== hw/five_port_register_file.sv
`timescale 1ns/10ps
// Behaviour
// - eight 8-bit words, five ports, each with data, address and enable.
// - read ports take address on the edge and show the word after it.
// - all five ports work every cycle while the CTRL enable bit is set, no arbitration or stall.
// - a read during a write to that word returns the old value.
// - write ports register and decode their address to steer data.
// - write data is stored one edge after the address edge.
// - colliding writes to one word store the OR of their data.
// - bidirectional direction is registered with its address.
// - direction 1 makes the bidirectional port read like a read port.
// - direction 0 makes the bidirectional port write like a write port.
// - port enables are registered with the address they apply to.
// - a high read port enable floats its data lines after the edge.
// - a high write port enable suppresses that port's write.
// - bidirectional enable is write or output enable by direction.
module five_port_register_file #(
  parameter int unsigned WORDS  = regfile_pkg::WORDS,
  parameter int unsigned WIDTH  = regfile_pkg::WIDTH,
  parameter int unsigned ADDR_W = regfile_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Read port 1
  input  wire logic [ADDR_W-1:0]               read_port1_addr_i,
  input  wire logic                            read_port1_out_en_n_i,
  output logic [WIDTH-1:0]                     read_port1_data_o,
  output logic                                 read_port1_data_oe_o,
  // Read port 2
  input  wire logic [ADDR_W-1:0]               read_port2_addr_i,
  input  wire logic                            read_port2_out_en_n_i,
  output logic [WIDTH-1:0]                     read_port2_data_o,
  output logic                                 read_port2_data_oe_o,
  // Write port 1
  input  wire logic [ADDR_W-1:0]               write_port1_addr_i,
  input  wire logic                            write_port1_wr_en_n_i,
  input  wire logic [WIDTH-1:0]                write_port1_data_i,
  // Write port 2
  input  wire logic [ADDR_W-1:0]               write_port2_addr_i,
  input  wire logic                            write_port2_wr_en_n_i,
  input  wire logic [WIDTH-1:0]                write_port2_data_i,
  // Bidirectional port
  input  wire logic [ADDR_W-1:0]               bidir_port_addr_i,
  input  wire logic                            bidir_direction_i,
  input  wire logic                            bidir_port_en_n_i,
  input  wire logic [WIDTH-1:0]                bidir_data_i,
  output logic [WIDTH-1:0]                     bidir_data_o,
  output logic                                 bidir_data_oe_o,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [regfile_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic [31:0]                          wb_dat_o,
  output logic                                 wb_ack_o
);
  import regfile_pkg::*;

  localparam int unsigned NWP = 3;

  initial begin
    if (WORDS != (1 << ADDR_W)) begin
      $error("five_port_register_file: WORDS must equal 2**ADDR_W");
    end
    if (WIDTH > 32 || WIDTH < 1) begin
      $error("five_port_register_file: WIDTH must be 1 to 32");
    end
    if (ADDR_W > 3) begin
      $error("five_port_register_file: peek window holds at most 8 words");
    end
  end

  logic [WIDTH-1:0] mem [WORDS];

  logic             ctrl_enable_r;
  logic             collide_r;
  logic             collide_nxt;
  logic             wb_ack_nxt;
  logic [31:0]      wb_dat_nxt;

  // Write port stages: index 0 and 1 are the write ports, 2 the bidirectional one.
  logic [WORDS-1:0] sel [NWP];
  logic [WIDTH-1:0] wdata [NWP];
  logic             bidir_wr_qual;

  assign bidir_wr_qual = ctrl_enable_r & (bidir_direction_i == DIR_WRITE);

  wr_port_stage #(.WORDS(WORDS), .ADDR_W(ADDR_W)) u_wr1 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .addr_i (write_port1_addr_i),
    .en_n_i (write_port1_wr_en_n_i),
    .qual_i (ctrl_enable_r),
    .sel_o  (sel[0])
  );

  wr_port_stage #(.WORDS(WORDS), .ADDR_W(ADDR_W)) u_wr2 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .addr_i (write_port2_addr_i),
    .en_n_i (write_port2_wr_en_n_i),
    .qual_i (ctrl_enable_r),
    .sel_o  (sel[1])
  );

  wr_port_stage #(.WORDS(WORDS), .ADDR_W(ADDR_W)) u_wrb (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .addr_i (bidir_port_addr_i),
    .en_n_i (bidir_port_en_n_i),
    .qual_i (bidir_wr_qual),
    .sel_o  (sel[2])
  );

  assign wdata[0] = write_port1_data_i;
  assign wdata[1] = write_port2_data_i;
  assign wdata[2] = bidir_data_i;

  // Per-word merge of all write ports.
  logic [WORDS-1:0] word_hit;
  logic [WORDS-1:0] word_collide;

  genvar w;
  generate
    for (w = 0; w < WORDS; w++) begin : g_word
      logic [WIDTH-1:0] word_or;
      assign word_or = ({WIDTH{sel[0][w]}} & wdata[0])
                     | ({WIDTH{sel[1][w]}} & wdata[1])
                     | ({WIDTH{sel[2][w]}} & wdata[2]);
      assign word_hit[w] = sel[0][w] | sel[1][w] | sel[2][w];
      assign word_collide[w] = (sel[0][w] & sel[1][w])
                             | (sel[0][w] & sel[2][w])
                             | (sel[1][w] & sel[2][w]);
      always_ff @(posedge clk_i) begin
        if (word_hit[w]) begin
          mem[w] <= word_or;
        end
      end
    end
  endgenerate

  // Read side. The output flops sample the array on the address edge, so a
  // write landing on the same edge is not yet visible to them.
  logic [WIDTH-1:0] rd1_word;
  logic [WIDTH-1:0] rd2_word;
  logic [WIDTH-1:0] rdb_word;
  logic             rd1_oe_nxt;
  logic             rd2_oe_nxt;
  logic             rdb_oe_nxt;

  assign rd1_word = mem[read_port1_addr_i];
  assign rd2_word = mem[read_port2_addr_i];
  assign rdb_word = mem[bidir_port_addr_i];

  assign rd1_oe_nxt = ctrl_enable_r & ~read_port1_out_en_n_i;
  assign rd2_oe_nxt = ctrl_enable_r & ~read_port2_out_en_n_i;
  assign rdb_oe_nxt = ctrl_enable_r & ~bidir_port_en_n_i & (bidir_direction_i == DIR_READ);

  // address and enable taken on the edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_port1_data_o    <= '0;
      read_port2_data_o    <= '0;
      bidir_data_o         <= '0;
      read_port1_data_oe_o <= 1'b0;
      read_port2_data_oe_o <= 1'b0;
      bidir_data_oe_o      <= 1'b0;
    end else begin
      read_port1_data_o    <= rd1_word;
      read_port2_data_o    <= rd2_word;
      bidir_data_o         <= rdb_word;
      read_port1_data_oe_o <= rd1_oe_nxt;
      read_port2_data_oe_o <= rd2_oe_nxt;
      bidir_data_oe_o      <= rdb_oe_nxt;
    end
  end

  // Wishbone slave: one wait state, ack lasts exactly one cycle.
  logic             wb_req;
  logic             wb_wr;
  logic             hit_ctrl;
  logic             hit_status;
  logic             hit_peek;
  logic [WIDTH-1:0] peek_word;
  logic             collide_clr;
  logic             collide_set;

  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr      = wb_req & wb_we_i & wb_sel_i[0];
  assign hit_ctrl   = (wb_adr_i == CTRL_OFS);
  assign hit_status = (wb_adr_i == STATUS_OFS);
  assign hit_peek   = ((wb_adr_i & PEEK_MASK) == PEEK_BASE_OFS);
  assign peek_word  = mem[wb_adr_i[ADDR_W+1:2]];

  // A collision on the clearing cycle keeps the flag set.
  assign collide_set = |word_collide;
  assign collide_clr = wb_wr & hit_status & wb_dat_i[STATUS_COLLIDE_BIT];
  assign collide_nxt = collide_set | (collide_r & ~collide_clr);
  assign wb_ack_nxt  = wb_req;

  always_comb begin
    wb_dat_nxt = WB_ZERO;
    if (hit_ctrl) begin
      wb_dat_nxt[CTRL_ENABLE_BIT] = ctrl_enable_r;
    end else if (hit_status) begin
      wb_dat_nxt[STATUS_COLLIDE_BIT] = collide_r;
    end else if (hit_peek) begin
      wb_dat_nxt[WIDTH-1:0] = peek_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_enable_r <= CTRL_ENABLE_RST;
      collide_r     <= COLLIDE_RST;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= WB_ZERO;
    end else begin
      collide_r <= collide_nxt;
      wb_ack_o  <= wb_ack_nxt;
      if (wb_req) begin
        wb_dat_o <= wb_dat_nxt;
      end
      if (wb_wr && hit_ctrl) begin
        ctrl_enable_r <= wb_dat_i[CTRL_ENABLE_BIT];
      end
    end
  end

endmodule

// ===== test/fpr_monitor.sv
`timescale 1ns/10ps
module fpr_monitor (
  // Clock and reset
  input wire logic       clk_i, rst_i,
  // Port signals
  input wire logic [2:0] read_port1_addr_i, read_port2_addr_i, write_port1_addr_i,
  input wire logic [2:0] bidir_port_addr_i,
  input wire logic [7:0] read_port1_data_o, read_port2_data_o, bidir_data_o,
  input wire logic [7:0] write_port1_data_i,
  input wire logic       read_port1_out_en_n_i, read_port1_data_oe_o, bidir_data_oe_o,
  input wire logic       write_port1_wr_en_n_i, write_port2_wr_en_n_i,
  input wire logic       bidir_port_en_n_i, bidir_direction_i,
  // Wishbone
  input wire logic       wb_cyc_i, wb_stb_i, wb_ack_o
);
  wire bd_idle = bidir_port_en_n_i || bidir_direction_i;
  wire quiet   = write_port1_wr_en_n_i && write_port2_wr_en_n_i && bd_idle;
  wire lone    = !write_port1_wr_en_n_i && write_port2_wr_en_n_i && bd_idle;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_lone_hold;
    (lone && read_port2_addr_i == write_port1_addr_i) ##1 $stable(read_port2_addr_i);
  endsequence
  property p_store;
    logic [2:0] a;
    logic [7:0] d;
    (lone, a = write_port1_addr_i) ##1 (1'h1, d = write_port1_data_i)
      ##1 (read_port1_addr_i == a) |=> read_port1_data_o === d;
  endproperty
  chk_old_kept: assert property ($past(quiet) ##0 s_lone_hold |=>
    read_port2_data_o === $past(read_port2_data_o)) else $error("read saw same-edge write");
  chk_store_new: assert property (p_store) else $error("write not stored");
  chk_float_rd: assert property (read_port1_out_en_n_i |=> !read_port1_data_oe_o)
    else $error("read port still driving");
  chk_drive_rd: assert property (!read_port1_out_en_n_i |=> read_port1_data_oe_o)
    else $error("read port not driving");
  chk_bidir_dir: assert property (bidir_direction_i && !bidir_port_en_n_i |=>
    bidir_data_oe_o) else $error("bidirectional read not driving");
  chk_bidir_off: assert property ((!bidir_direction_i || bidir_port_en_n_i) |=>
    !bidir_data_oe_o) else $error("bidirectional port driving");
  chk_bidir_read: assert property (bidir_direction_i &&
    bidir_port_addr_i == read_port1_addr_i |=> bidir_data_o === read_port1_data_o)
    else $error("bidirectional read differs");
  chk_ports_agree: assert property (read_port1_addr_i == read_port2_addr_i |=>
    read_port1_data_o === read_port2_data_o) else $error("read ports differ");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
endmodule
bind five_port_register_file fpr_monitor mon (.*);

// ===== test/fpr_sequencer.sv
`timescale 1ns/10ps
module fpr_sequencer (
  // Clock
  input  wire logic       clk_i,
  // Requests as issued at the address edge
  input  wire logic       w1_en_n_i, w2_en_n_i, bd_en_n_i, bd_dir_i,
  input  wire logic [7:0] w1_d_i, w2_d_i, bd_d_i,
  // Device side of the shared data lines
  input  wire logic       bd_oe_i,
  input  wire logic [7:0] bd_q_i,
  // Data lines into the device
  output logic [7:0]      w1_o, w2_o, bd_o
);
  import regfile_pkg::*;
  logic       bd_wr_r = 1'h0;
  logic [7:0] bd_r    = 8'h00;
  logic [7:0] pat_r   = 8'h00;
  // Outside a data cycle the lines move every cycle, so a mistimed sample never matches.
  always_ff @(posedge clk_i) begin
    w1_o    <= w1_en_n_i ? pat_r : w1_d_i;
    w2_o    <= w2_en_n_i ? ~pat_r : w2_d_i;
    bd_wr_r <= !bd_en_n_i && bd_dir_i == DIR_WRITE;
    bd_r    <= bd_d_i;
    pat_r   <= pat_r + 8'h35;
  end
  assign bd_o = bd_oe_i ? bd_q_i : (bd_wr_r ? bd_r : pat_r);
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
  import regfile_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [2:0]  r1a = 3'h0, r2a = 3'h0, w1a = 3'h0, w2a = 3'h0, ba = 3'h0;
  logic        r1e = 1'h1, r2e = 1'h1, w1e = 1'h1, w2e = 1'h1, be = 1'h1, bdir = 1'h1;
  logic [7:0]  w1d = 8'h00, w2d = 8'h00, bd = 8'h00, adr = 8'h00, pat [8];
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd = 32'h0, q;
  wire  [7:0]  d1, d2, bq, p1, p2, pb;
  wire  [31:0] wq;
  wire         oe1, oe2, oeb, ack;
  int          n_errors = 0, n_tests = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  five_port_register_file uut (.clk_i(clk_i), .rst_i(rst_i),
    .read_port1_addr_i(r1a), .read_port1_out_en_n_i(r1e), .read_port1_data_o(d1),
    .read_port1_data_oe_o(oe1), .read_port2_addr_i(r2a), .read_port2_out_en_n_i(r2e),
    .read_port2_data_o(d2), .read_port2_data_oe_o(oe2), .write_port1_addr_i(w1a),
    .write_port1_wr_en_n_i(w1e), .write_port1_data_i(p1), .write_port2_addr_i(w2a),
    .write_port2_wr_en_n_i(w2e), .write_port2_data_i(p2), .bidir_port_addr_i(ba),
    .bidir_direction_i(bdir), .bidir_port_en_n_i(be), .bidir_data_i(pb), .bidir_data_o(bq),
    .bidir_data_oe_o(oeb), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wq), .wb_ack_o(ack));
  fpr_sequencer far (.clk_i(clk_i), .w1_en_n_i(w1e), .w2_en_n_i(w2e), .bd_en_n_i(be),
    .bd_dir_i(bdir), .w1_d_i(w1d), .w2_d_i(w2d), .bd_d_i(bd), .bd_oe_i(oeb), .bd_q_i(bq),
    .w1_o(p1), .w2_o(p2), .bd_o(pb));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, sel, adr, wd} <= {2'h3, w, 4'hf, a, d};
    // Ack and read data are taken at the rising edge that samples ack high.
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = wq;
    chk("ack", 1'h1, ack);
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rd3(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    {r1a, r2a, ba, r1e, r2e, be, bdir} <= {a, a, a, 4'h1};
    @(posedge clk_i);
    #1 chk("read data", {3{e}}, {d1, d2, bq});
    chk("read enables", 3'h7, {oe1, oe2, oeb});
  endtask
  task automatic idle();
    @(posedge clk_i);
    {w1e, w2e, be} <= 3'h7;
  endtask
  // A hung bus wait must still reach the verdict, so the run is capped here.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    #1 chk("reset enables", 3'h0, {oe1, oe2, oeb});
    wb(0, CTRL_OFS, 0);
    chk("ctrl", 32'h1, q);
    wb(0, STATUS_OFS, 0);
    chk("status", 32'h0, q);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pat[i] = 8'(i * 37 + 5);
      @(posedge clk_i);
      {w1a, w1e, w1d} <= {3'(i), 1'h0, pat[i]};
    end
    idle();
    for (int i = 0; i < 8; i++) begin
      rd3(3'(i), pat[i]);
      wb(0, PEEK_BASE_OFS + 8'(4 * i), 0);
      chk("peek", 32'(pat[i]), q);
    end
    wb(0, 8'h10, 0);
    chk("unmapped", 32'h0, q);
    $display("test fill done");
    @(posedge clk_i);
    {w1a, w1e, w1d, r1a, r2a} <= {3'h2, 1'h0, 8'h5a, 3'h2, 3'h2};
    idle();
    @(posedge clk_i);
    #1 chk("old word", pat[2], d1);
    @(posedge clk_i);
    #1 chk("new word", 8'h5a, d1);
    $display("test same edge done");
    @(posedge clk_i);
    {w1a, w2a, ba, w1e, w2e, be, bdir, w1d, w2d, bd} <= {3'h5, 3'h5, 3'h5, 4'h0, 24'h013084};
    idle();
    rd3(3'h5, 8'hb5);
    wb(0, STATUS_OFS, 0);
    chk("collision", 32'h1, q);
    wb(1, STATUS_OFS, 32'h1);
    wb(0, STATUS_OFS, 0);
    chk("cleared", 32'h0, q);
    $display("test collision done");
    @(posedge clk_i);
    {w1a, ba, w1e, be, bdir, r1e, w1d, bd} <= {6'h00, 4'hd, 16'hffff};
    @(posedge clk_i);
    #1 chk("disabled enables", 3'h2, {oe1, oe2, oeb});
    rd3(3'h0, pat[0]);
    $display("test enables done");
    print_verdict();
  end
endmodule
